/* File: hdl/ptx_pkg.sv */
// Purpose: Shared constants and types for the parallel MII transmit capture.
// Assumes: mclk runs at 125 MHz; link clock comes from the far side or loops back.
// Notes: Mode codes form a Gray sequence in list order; decodeMode maps the speed and double-rate straps.
package ptx_pkg;

  typedef enum logic [2:0] {
    PTX_MII       = 3'h0,
    PTX_GMII      = 3'h1,
    PTX_RGMII10   = 3'h3,
    PTX_RGMII100  = 3'h2,
    PTX_RGMII1000 = 3'h6,
    PTX_TBI       = 3'h7,
    PTX_RTBI      = 3'h5
  } ptx_mode_t;

  localparam ptx_mode_t MODE_RST = PTX_MII;

  // Word layout of the assembled transmit word
  localparam int WORD_W = 10;
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam int TBI_EN_POS = 8;
  localparam int TBI_ER_POS = 9;
  localparam int RTBI_RISE_CTL_POS = 4;
  localparam int RTBI_FALL_POS = 5;
  localparam int RTBI_FALL_CTL_POS = 9;
  localparam logic [9:0] WORD_RST = 10'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;

  // Clock rates in kHz for the DCE transmit clock
  localparam int MCLK_KHZ = 125000;
  localparam int TXCLK_100_KHZ = 25000;
  localparam int TXCLK_10_KHZ = 2500;
  localparam int DIV100_CYC = MCLK_KHZ / TXCLK_100_KHZ;
  localparam int DIV10_CYC = MCLK_KHZ / TXCLK_10_KHZ;
  localparam logic [5:0] DIV100 = 6'(DIV100_CYC);
  localparam logic [5:0] DIV10 = 6'(DIV10_CYC);
  localparam logic [5:0] DIV_RST = 6'h00;

endpackage : ptx_pkg

/* File: hdl/ptx_fall_capture.sv */
// Purpose: Falling-edge sampler of the low nibble and control pin.
// Assumes: linkRstn is already released in step with linkClk.
// Notes: Read by the rising-edge logic half a cycle later.
`timescale 1ns/1ps
module ptx_fall_capture (
  input wire logic linkClk,
  input wire logic linkRstn,
  input wire logic [3:0] txdLow,
  input wire logic txCtl,
  output logic [3:0] fallData,
  output logic fallCtl
);

  typedef struct packed {
    logic [3:0] data;
    logic ctl;
  } ptx_fall_t;

  ptx_fall_t st;
  ptx_fall_t next_st;

  always_comb begin
    next_st = st;
    next_st.data = txdLow;
    next_st.ctl = txCtl;
  end

  always_ff @(negedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fallData = st.data;
  assign fallCtl = st.ctl;

endmodule : ptx_fall_capture

/* File: hdl/ptx_capture.sv */
// Purpose: Transmit-side capture of the parallel MII, all parallel modes.
// Assumes: spd, ddr and dceSel come from configuration logic on mclk.
// Notes: In DCE mode the driven transmit clock must be looped back to linkClk.
// Operation
// - Four or eight data inputs used, chosen by mode.
// - GMII: rising link edge latches all eight data bits.
// - MII and RGMII-10/100: rising edge latches low nibble only.
// - RGMII-1000: low nibble on rising, high nibble on falling edge.
// - TBI: eight data bits, enable as bit 8, error as bit 9.
// - RTBI rising edge: low nibble plus enable as bit 4.
// - RTBI falling edge: nibble into bits 8:5, enable as bit 9.
// - MII and GMII: enable sampled on rising link edge.
// - RGMII: control pin sampled on both link edges.
// - MII and GMII: error sampled on rising link edge.
// - Error pin ignored in RGMII and RTBI modes.
// - Upper four data pins unused in MII, RGMII and RTBI.
// - MII clock 25 or 2.5 MHz; device drives it in DCE.
`timescale 1ns/1ps
module ptx_capture (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [1:0] spd,
  input wire logic ddr,
  input wire logic dceSel,
  input wire logic linkClk,
  input wire logic [7:0] txd,
  input wire logic txEn,
  input wire logic txEr,
  output logic [9:0] txWord,
  output logic txEnable,
  output logic txError,
  output logic wordValid,
  output logic upperFree,
  output logic linkActive,
  output logic txClkOut,
  output logic txClkOen
);

  // Maps the speed and double-rate settings onto a capture mode
  function automatic ptx_pkg::ptx_mode_t decodeMode(input logic [1:0] s, input logic d);
    ptx_pkg::ptx_mode_t r;
    r = ptx_pkg::MODE_RST;
    case ({d, s})
      3'h0: r = ptx_pkg::PTX_MII;
      3'h1: r = ptx_pkg::PTX_MII;
      3'h2: r = ptx_pkg::PTX_GMII;
      3'h3: r = ptx_pkg::PTX_TBI;
      3'h4: r = ptx_pkg::PTX_RGMII10;
      3'h5: r = ptx_pkg::PTX_RGMII100;
      3'h6: r = ptx_pkg::PTX_RGMII1000;
      3'h7: r = ptx_pkg::PTX_RTBI;
      default: r = ptx_pkg::MODE_RST;
    endcase
    return r;
  endfunction : decodeMode

  // Eight data pins only in GMII and TBI
  function automatic logic wideData(input ptx_pkg::ptx_mode_t md);
    return (md == ptx_pkg::PTX_GMII) || (md == ptx_pkg::PTX_TBI);
  endfunction : wideData

  function automatic logic isRgmii(input ptx_pkg::ptx_mode_t md);
    return (md == ptx_pkg::PTX_RGMII10) || (md == ptx_pkg::PTX_RGMII100) ||
           (md == ptx_pkg::PTX_RGMII1000);
  endfunction : isRgmii

  // ---------------- mclk domain ----------------
  typedef struct packed {
    ptx_pkg::ptx_mode_t mode;
    logic upperFree;
    logic [5:0] divCnt;
    logic clkOut;
    logic clkOen;
    logic [1:0] actSync;
    logic active;
  } ptx_sys_t;

  ptx_sys_t sys;
  ptx_sys_t next_sys;
  logic linkActiveRaw;

  always_comb begin
    logic [5:0] period;
    logic driveClk;
    period = ptx_pkg::DIV_RST;
    driveClk = 1'b0;
    next_sys = sys;
    next_sys.mode = decodeMode(spd, ddr);
    next_sys.upperFree = !wideData(sys.mode);
    // DCE MII: device makes the transmit clock from mclk
    driveClk = dceSel && (sys.mode == ptx_pkg::PTX_MII);
    period = spd[0] ? ptx_pkg::DIV100 : ptx_pkg::DIV10;
    if (driveClk) begin
      if (sys.divCnt >= period - 6'h01) begin
        next_sys.divCnt = ptx_pkg::DIV_RST;
      end else begin
        next_sys.divCnt = sys.divCnt + 6'h01;
      end
      // Odd 25 MHz period gives a 2:3 duty, within MII limits
      next_sys.clkOut = (sys.divCnt < (period >> 1));
      next_sys.clkOen = 1'b0;
    end else begin
      next_sys.divCnt = ptx_pkg::DIV_RST;
      next_sys.clkOut = 1'b0;
      next_sys.clkOen = 1'b1;
    end
    // Level from the link side, two flops before use
    next_sys.actSync = {sys.actSync[0], linkActiveRaw};
    next_sys.active = sys.actSync[1];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sys.mode <= ptx_pkg::MODE_RST;
      sys.upperFree <= 1'b1;
      sys.divCnt <= ptx_pkg::DIV_RST;
      sys.clkOut <= 1'b0;
      sys.clkOen <= 1'b1;
      sys.actSync <= 2'h0;
      sys.active <= 1'b0;
    end else begin
      sys <= next_sys;
    end
  end

  assign upperFree = sys.upperFree;
  assign linkActive = sys.active;
  assign txClkOut = sys.clkOut;
  assign txClkOen = sys.clkOen;

  // ---------------- link domain ----------------
  // Reset asserts at once, releases on the link clock
  logic [1:0] linkRstSync;
  logic linkRstn;

  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      linkRstSync <= 2'h0;
    end else begin
      linkRstSync <= {linkRstSync[0], 1'b1};
    end
  end

  assign linkRstn = linkRstSync[1];

  typedef struct packed {
    ptx_pkg::ptx_mode_t modeS1;
    ptx_pkg::ptx_mode_t modeS2;
    ptx_pkg::ptx_mode_t modeS3;
    ptx_pkg::ptx_mode_t mode;
    logic [7:0] riseData;
    logic riseEn;
    logic riseEr;
    logic [9:0] word;
    logic en;
    logic er;
    logic valid;
  } ptx_link_t;

  ptx_link_t lnk;
  ptx_link_t next_lnk;
  logic [3:0] fallData;
  logic fallCtl;

  ptx_fall_capture fallCap (
    .linkClk(linkClk),
    .linkRstn(linkRstn),
    .txdLow(txd[3:0]),
    .txCtl(txEn),
    .fallData(fallData),
    .fallCtl(fallCtl)
  );

  always_comb begin
    next_lnk = lnk;
    // Mode is static in use; take it only after two equal samples
    next_lnk.modeS1 = sys.mode;
    next_lnk.modeS2 = lnk.modeS1;
    next_lnk.modeS3 = lnk.modeS2;
    if (lnk.modeS3 == lnk.modeS2) begin
      next_lnk.mode = lnk.modeS3;
    end
    // Rising-edge samples; upper pins masked when they are GPIO
    next_lnk.riseData = wideData(lnk.mode) ? txd : {ptx_pkg::NIB_RST, txd[3:0]};
    next_lnk.riseEn = txEn;
    next_lnk.riseEr = isRgmii(lnk.mode) ? 1'b0 : txEr;
    next_lnk.word = ptx_pkg::WORD_RST;
    next_lnk.en = 1'b0;
    next_lnk.er = 1'b0;
    // Assembly uses the rise sample and the following fall sample
    case (lnk.mode)
      ptx_pkg::PTX_GMII: begin
        next_lnk.word = {2'h0, lnk.riseData};
        next_lnk.en = lnk.riseEn;
        next_lnk.er = lnk.riseEr;
      end
      ptx_pkg::PTX_MII: begin
        next_lnk.word[ptx_pkg::NIB_LO +: 4] = lnk.riseData[3:0];
        next_lnk.en = lnk.riseEn;
        next_lnk.er = lnk.riseEr;
      end
      ptx_pkg::PTX_RGMII10, ptx_pkg::PTX_RGMII100: begin
        next_lnk.word[ptx_pkg::NIB_LO +: 4] = lnk.riseData[3:0];
        next_lnk.en = lnk.riseEn;
        next_lnk.er = lnk.riseEn ^ fallCtl;
      end
      ptx_pkg::PTX_RGMII1000: begin
        next_lnk.word[ptx_pkg::NIB_LO +: 4] = lnk.riseData[3:0];
        next_lnk.word[ptx_pkg::NIB_HI +: 4] = fallData;
        next_lnk.en = lnk.riseEn;
        next_lnk.er = lnk.riseEn ^ fallCtl;
      end
      ptx_pkg::PTX_TBI: begin
        next_lnk.word[7:0] = lnk.riseData;
        next_lnk.word[ptx_pkg::TBI_EN_POS] = lnk.riseEn;
        next_lnk.word[ptx_pkg::TBI_ER_POS] = lnk.riseEr;
      end
      ptx_pkg::PTX_RTBI: begin
        next_lnk.word[ptx_pkg::NIB_LO +: 4] = lnk.riseData[3:0];
        next_lnk.word[ptx_pkg::RTBI_RISE_CTL_POS] = lnk.riseEn;
        next_lnk.word[ptx_pkg::RTBI_FALL_POS +: 4] = fallData;
        next_lnk.word[ptx_pkg::RTBI_FALL_CTL_POS] = fallCtl;
      end
      default: begin
        next_lnk.word = ptx_pkg::WORD_RST;
      end
    endcase
    // A word every cycle once the mode has settled
    next_lnk.valid = (lnk.modeS3 == lnk.mode);
  end

  always_ff @(posedge linkClk or negedge linkRstn) begin
    if (!linkRstn) begin
      lnk.modeS1 <= ptx_pkg::MODE_RST;
      lnk.modeS2 <= ptx_pkg::MODE_RST;
      lnk.modeS3 <= ptx_pkg::MODE_RST;
      lnk.mode <= ptx_pkg::MODE_RST;
      lnk.riseData <= ptx_pkg::DATA_RST;
      lnk.riseEn <= 1'b0;
      lnk.riseEr <= 1'b0;
      lnk.word <= ptx_pkg::WORD_RST;
      lnk.en <= 1'b0;
      lnk.er <= 1'b0;
      lnk.valid <= 1'b0;
    end else begin
      lnk <= next_lnk;
    end
  end

  assign txWord = lnk.word;
  assign txEnable = lnk.en;
  assign txError = lnk.er;
  assign wordValid = lnk.valid;
  assign linkActiveRaw = lnk.en;

endmodule : ptx_capture

/* File: verification/ptx_capture_props.sv */
// Purpose: Port checks for the transmit capture.
// Assumes: Mode inputs are quasi-static.
// Notes: Checks wait for 15 quiet cycles after a mode move.
`timescale 1ns/1ps
module ptx_capture_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [1:0] spd,
  input wire logic ddr,
  input wire logic dceSel,
  input wire logic linkClk,
  input wire logic [7:0] txd,
  input wire logic txEn,
  input wire logic txEr,
  input wire logic [9:0] txWord,
  input wire logic txEnable,
  input wire logic txError,
  input wire logic wordValid,
  input wire logic upperFree,
  input wire logic linkActive,
  input wire logic txClkOut,
  input wire logic txClkOen
);
  logic [9:0] r1, r2;
  logic [4:0] fp, f1;
  logic [3:0] lCfg, mCfg, lAge, mAge;
  wire [3:0] cfg = {spd, ddr, dceSel};
  wire ok = wordValid && lAge == 4'hF && lCfg == cfg;
  wire dce = mAge == 4'hF && mCfg == cfg && cfg == 4'h5;
  always_ff @(negedge linkClk) fp <= {txEn, txd[3:0]};
  always_ff @(posedge linkClk) begin
    r1 <= {txEr, txEn, txd};
    r2 <= r1;
    f1 <= fp;
  end
  // Ages hide the few cycles the mode needs to cross
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      lCfg <= 4'h0;
      lAge <= 4'h0;
    end else begin
      lCfg <= cfg;
      lAge <= (lCfg != cfg) ? 4'h0 : lAge + {3'h0, lAge != 4'hF};
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mCfg <= 4'h0;
      mAge <= 4'h0;
    end else begin
      mCfg <= cfg;
      mAge <= (mCfg != cfg) ? 4'h0 : mAge + {3'h0, mAge != 4'hF};
    end
  end
  AST_GMII_WORD: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && spd == 2'h2 && !ddr |-> txWord == {2'h0, r2[7:0]}) else $error("gmii word");
  AST_NIB_WORD: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && !spd[1] |-> txWord == {6'h0, r2[3:0]}) else $error("nibble word");
  AST_DDR_WORD: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && spd == 2'h2 && ddr |-> txWord == {2'h0, f1[3:0], r2[3:0]}) else $error("ddr word");
  AST_TBI_WORD: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && spd == 2'h3 && !ddr |-> txWord == r2 && !txEnable && !txError) else $error("tbi");
  AST_RTBI_WORD: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && spd == 2'h3 && ddr |-> txWord == {f1, r2[8], r2[3:0]}) else $error("rtbi");
  AST_SDR_QUAL: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && !ddr && spd != 2'h3 |-> txEnable == r2[8] && txError == r2[9]) else $error("sdr");
  AST_RGMII_QUAL: assert property (@(posedge linkClk) disable iff (!resetn)
    ok && ddr && spd != 2'h3 |-> txEnable == r2[8] && txError == (r2[8] ^ f1[4]))
    else $error("rgmii qualifiers");
  // Looks back over the last period, so a later mode move cannot trip it
  AST_DCE_CLK: assert property (@(posedge mclk) disable iff (!resetn)
    dce && $rose(txClkOut) |-> !txClkOen && !$past(txClkOut, 2) && !$past(txClkOut, 3) &&
    $past(txClkOut, 4) && $past(txClkOut, 5) && !$past(txClkOut, 6))
    else $error("dce clock shape");
  cover property (@(posedge linkClk) ok && ddr && spd != 2'h3 && txError);
  cover property (@(posedge linkClk) ok && spd == 2'h3 && ddr);
  cover property (@(posedge mclk) dce && $rose(txClkOut));
  cover property (@(posedge mclk) linkActive);
endmodule : ptx_capture_props

bind ptx_capture ptx_capture_props i_props (.mclk(mclk), .resetn(resetn), .spd(spd),
  .ddr(ddr), .dceSel(dceSel), .linkClk(linkClk), .txd(txd), .txEn(txEn), .txEr(txEr),
  .txWord(txWord), .txEnable(txEnable), .txError(txError), .wordValid(wordValid),
  .upperFree(upperFree), .linkActive(linkActive), .txClkOut(txClkOut), .txClkOen(txClkOen));

/* File: verification/ptx_mac_model.sv */
// Purpose: Behavioural MAC driving the parallel transmit pins.
// Assumes: Pins move 1 ns after every link clock edge.
// Notes: Shift-register pattern keeps every pin toggling.
`timescale 1ns/1ps
module ptx_mac_model (
  input wire logic linkClk,
  output logic genClk,
  output logic [7:0] txd,
  output logic txEn,
  output logic txEr
);
  logic [7:0] seq = 8'h5A;
  logic clkGen = 1'b0;
  // One process drives txd, txEn and txEr; they are unknown only until the first edge, inside reset
  assign genClk = clkGen;
  always #15 clkGen = ~clkGen;
  // Both edges move pins, so a wrong edge choice shows
  always @(linkClk) begin
    #1;
    seq = {seq[6:0], seq[7] ^ seq[5] ^ seq[4] ^ seq[3]};
    txd = seq ^ 8'hC3;
    txEn = seq[1] ^ seq[6];
    txEr = seq[4];
  end
endmodule : ptx_mac_model

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the transmit capture.
// Assumes: Partner model makes the link clock outside DCE.
// Notes: In DCE the driven clock loops back to the link input.
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ddr = 1'b0;
  logic dceSel = 1'b0;
  logic [1:0] spd = 2'h0;
  logic genClk, txEn, txEr, txEnable, txError, wordValid, upperFree, linkActive;
  logic txClkOut, txClkOen;
  logic [7:0] txd;
  logic [9:0] txWord;
  int errors = 0;
  int num_checks = 0;
  wire linkClk = dceSel ? txClkOut : genClk;
  always #4 mclk = ~mclk;
  ptx_mac_model i_mac (.linkClk(linkClk), .genClk(genClk), .txd(txd), .txEn(txEn), .txEr(txEr));
  ptx_capture i_dut (.mclk(mclk), .resetn(resetn), .spd(spd), .ddr(ddr), .dceSel(dceSel),
    .linkClk(linkClk), .txd(txd), .txEn(txEn), .txEr(txEr), .txWord(txWord),
    .txEnable(txEnable), .txError(txError), .wordValid(wordValid), .upperFree(upperFree),
    .linkActive(linkActive), .txClkOut(txClkOut), .txClkOen(txClkOen));
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic set_mode(input logic [1:0] s, input logic d, input logic c);
    int n;
    @(negedge mclk);
    spd = s;
    ddr = d;
    dceSel = c;
    repeat (8) @(posedge linkClk);
    n = 0;
    while (wordValid !== 1'b1 && n < 50) begin
      @(posedge linkClk);
      n++;
    end
    if (wordValid !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask : set_mode
  task automatic capture(input logic [1:0] s, input logic d);
    logic [9:0] r, n, w;
    logic [4:0] f;
    logic en, er;
    set_mode(s, d, dceSel);
    @(posedge linkClk);
    r = {txEr, txEn, txd};
    // Long enough to outlast the checker's quiet time after a mode move
    repeat (12) begin
      @(negedge linkClk);
      f = {txEn, txd[3:0]};
      @(posedge linkClk);
      n = {txEr, txEn, txd};
      #2;
      en = (s != 2'h3) ? r[8] : 1'b0;
      er = (s == 2'h3) ? 1'b0 : (d ? r[8] ^ f[4] : r[9]);
      case ({s, d})
        3'h6: w = r;
        3'h7: w = {f, r[8], r[3:0]};
        3'h4: w = {2'h0, r[7:0]};
        3'h5: w = {2'h0, f[3:0], r[3:0]};
        default: w = {6'h0, r[3:0]};
      endcase
      chk("word", w, txWord);
      chk("qual", {8'h0, en, er}, {8'h0, txEnable, txError});
      chk("valid", 10'h1, {9'h0, wordValid});
      r = n;
    end
    chk("free", {9'h0, !(s[1] && !d)}, {9'h0, upperFree});
    // Code groups carry no enable qualifier, so the status stays low
    if (s == 2'h3) begin
      chk("active", 10'h0, {9'h0, linkActive});
    end
  endtask : capture
  task automatic clk_count(input logic [1:0] s, input logic [9:0] hiExp, input logic [9:0] rsExp);
    int hi, rs;
    logic prev;
    set_mode(s, 1'b0, 1'b1);
    hi = 0;
    rs = 0;
    // Start half a cycle in, so the window holds whole periods and every rise
    @(negedge mclk);
    prev = txClkOut;
    repeat (100) begin
      @(negedge mclk);
      hi += int'(txClkOut === 1'b1);
      rs += int'(txClkOut === 1'b1 && prev === 1'b0);
      prev = txClkOut;
    end
    chk("high", hiExp, 10'(hi));
    chk("rises", rsExp, 10'(rs));
    chk("oen", 10'h0, {9'h0, txClkOen});
  endtask : clk_count
  task automatic test_modes;
    for (int i = 0; i < 8; i++) begin
      capture(2'(i >> 1), i[0]);
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_dce;
    clk_count(2'h1, 10'h28, 10'h14);
    capture(2'h1, 1'b0);
    clk_count(2'h0, 10'h32, 10'h02);
    @(negedge mclk);
    spd = 2'h2;
    repeat (4) @(negedge mclk);
    chk("refused", 10'h2, {8'h0, txClkOen, txClkOut});
    dceSel = 1'b0;
    $display("test dce done");
  endtask : test_dce
  initial begin
    repeat (12) @(negedge mclk);
    chk("reset", 10'h6, {7'h0, txClkOen, upperFree, wordValid});
    $display("test reset done");
    resetn = 1'b1;
    test_modes();
    test_dce();
    conclude();
  end
  initial begin
    #500000;
    errors++;
    conclude();
  end
endmodule : tb
